//--- hw/tcc_cfg.svh
// Register offsets, field positions, reset values and timing counts for the capture/compare channel.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_OFF_OVERCAPTURE   8'h07
`define TCC_OFF_EVENTGEN      8'h08
`define TCC_OFF_CH1MODE       8'h09
`define TCC_OFF_CH2MODE       8'h0a
`define TCC_OFF_CHCTRL        8'h0b
`define TCC_OFF_EVSTATUS      8'h06
`define TCC_OFF_CMP1HI        8'h11
`define TCC_OFF_CMP1LO        8'h12
`define TCC_OFF_CMP2HI        8'h13
`define TCC_OFF_CMP2LO        8'h14
`define TCC_OFF_IRQEN         8'h05

`define TCC_RST_BYTE          8'h00
`define TCC_RST_WORD          16'h0000

`define TCC_BIT_BREAK         7
`define TCC_BIT_TRIGGER       6
`define TCC_BIT_UPDATE        0

`define TCC_FAST_DELAY        3
`define TCC_NORMAL_DELAY      5

`endif

//--- hw/tcc_pkg.sv
// Types shared by the capture/compare channel.
// Assumes the configuration header is compiled alongside.
`default_nettype none

package tcc_pkg;
    typedef enum logic [2:0] {
        TCC_FROZEN  = 3'b000,
        TCC_SETHI   = 3'b001,
        TCC_SETLO   = 3'b010,
        TCC_TOGGLE  = 3'b011,
        TCC_FORCELO = 3'b100,
        TCC_FORCEHI = 3'b101,
        TCC_PWM1    = 3'b110,
        TCC_PWM2    = 3'b111
    } tcc_mode_t;

    typedef enum logic [1:0] {
        TCC_SEL_OUT   = 2'b00,
        TCC_SEL_OWN   = 2'b01,
        TCC_SEL_NEIGH = 2'b10,
        TCC_SEL_TRIG  = 2'b11
    } tcc_sel_t;
endpackage

`default_nettype wire

//--- hw/tcc_channel.sv
// Per-channel filter, capture divider, compare output and the top register block.
// Assumes counter, direction and update/trigger come from the neighbouring time base.
//
// The strobed register port was decided locally.
`include "tcc_cfg.svh"
`default_nettype none

module tcc_channel (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  modeReg,
    input  wire logic        chEnable,
    input  wire logic        polarity,
    input  wire logic        pinOwn,
    input  wire logic        pinNeighbour,
    input  wire logic        trigSource,
    input  wire logic        trigEdge,
    input  wire logic        countDown,
    input  wire logic [15:0] counterValue,
    input  wire logic [15:0] compareWrite,
    input  wire logic        compareWe,
    input  wire logic        updateEvent,
    input  wire logic        softEvent,
    input  wire logic        modeWe,
    output logic             captureEvent,
    output logic             compareMatch,
    output logic [15:0]      compareValue,
    output logic [15:0]      compareActive,
    output logic             outRef,
    output logic             filtOut
);
    tcc_pkg::tcc_mode_t mode;
    tcc_pkg::tcc_sel_t  sel;
    logic        isInput;
    logic [4:0]  sampleDiv;
    logic [3:0]  needCount;
    logic [4:0]  divCnt;
    logic [3:0]  eqCnt;
    logic        rawIn;
    logic        inPrev;
    logic        edgeSeen;
    logic [2:0]  pscCnt;
    logic [1:0]  pscRatio;
    logic [2:0]  pscLimit;
    logic        cmpLess;
    logic        cmpLessPrev;
    logic        wasFrozen;
    logic [2:0]  fastCnt;

    assign mode    = tcc_pkg::tcc_mode_t'(modeReg[6:4]);
    assign sel     = tcc_pkg::tcc_sel_t'(modeReg[1:0]);
    assign isInput = (sel != tcc_pkg::TCC_SEL_OUT);

    // Filter sampling divider and sample count
    always_comb begin
        case (modeReg[7:4])
            4'h1: begin sampleDiv = 5'h00; needCount = 4'h2; end
            4'h2: begin sampleDiv = 5'h00; needCount = 4'h4; end
            4'h3: begin sampleDiv = 5'h00; needCount = 4'h8; end
            4'h4: begin sampleDiv = 5'h01; needCount = 4'h6; end
            4'h5: begin sampleDiv = 5'h01; needCount = 4'h8; end
            4'h6: begin sampleDiv = 5'h03; needCount = 4'h6; end
            4'h7: begin sampleDiv = 5'h03; needCount = 4'h8; end
            4'h8: begin sampleDiv = 5'h07; needCount = 4'h6; end
            4'h9: begin sampleDiv = 5'h07; needCount = 4'h8; end
            4'ha: begin sampleDiv = 5'h0f; needCount = 4'h5; end
            4'hb: begin sampleDiv = 5'h0f; needCount = 4'h6; end
            4'hc: begin sampleDiv = 5'h0f; needCount = 4'h8; end
            4'hd: begin sampleDiv = 5'h1f; needCount = 4'h5; end
            4'he: begin sampleDiv = 5'h1f; needCount = 4'h6; end
            4'hf: begin sampleDiv = 5'h1f; needCount = 4'h8; end
            default: begin sampleDiv = 5'h00; needCount = 4'h1; end
        endcase
    end

    // Input source by selection
    always_comb begin
        case (sel)
            tcc_pkg::TCC_SEL_OWN:   rawIn = pinOwn;
            tcc_pkg::TCC_SEL_NEIGH: rawIn = pinNeighbour;
            tcc_pkg::TCC_SEL_TRIG:  rawIn = trigSource;
            default:                rawIn = 1'b0;
        endcase
    end

    // Digital filter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt  <= 5'h00;
            eqCnt   <= 4'h0;
            filtOut <= 1'b0;
        end else if (divCnt >= sampleDiv) begin
            divCnt <= 5'h00;
            if (rawIn == filtOut) begin
                eqCnt <= 4'h0;
            end else if (eqCnt + 4'h1 >= needCount) begin
                eqCnt   <= 4'h0;
                filtOut <= rawIn;
            end else begin
                eqCnt <= eqCnt + 4'h1;
            end
        end else begin
            divCnt <= divCnt + 5'h01;
        end
    end

    // Edge detect on filtered input, polarity picks edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inPrev <= 1'b0;
        end else begin
            inPrev <= filtOut;
        end
    end
    assign edgeSeen = polarity ? (inPrev & ~filtOut) : (~inPrev & filtOut);

    // Capture divider keeps old ratio until a capture
    assign pscLimit = (pscRatio == 2'b00) ? 3'h0 : (pscRatio == 2'b01) ? 3'h1 : (pscRatio == 2'b10) ? 3'h3 : 3'h7;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pscCnt       <= 3'h0;
            pscRatio     <= 2'b00;
            captureEvent <= 1'b0;
        end else if (!chEnable) begin
            pscCnt       <= 3'h0;
            pscRatio     <= modeReg[3:2];
            captureEvent <= 1'b0;
        end else begin
            captureEvent <= 1'b0;
            if (isInput && edgeSeen) begin
                if (pscCnt == pscLimit) begin
                    pscCnt       <= 3'h0;
                    pscRatio     <= modeReg[3:2];
                    captureEvent <= 1'b1;
                end else begin
                    pscCnt <= pscCnt + 3'h1;
                end
            end
        end
    end

    // Compare value with optional preload; captures overwrite it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            compareValue  <= `TCC_RST_WORD;
            compareActive <= `TCC_RST_WORD;
        end else if (isInput && ((captureEvent) || softEvent)) begin
            compareValue  <= counterValue;
            compareActive <= counterValue;
        end else begin
            if (compareWe) begin
                compareValue <= compareWrite;
            end
            if (compareWe && !modeReg[3]) begin
                compareActive <= compareWrite;
            end else if (updateEvent && modeReg[3]) begin
                compareActive <= compareValue;
            end
        end
    end

    assign cmpLess = countDown ? (counterValue <= compareActive) : (counterValue < compareActive);

    // Fast trigger path and normal delay pipeline
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fastCnt <= 3'h0;
        end else if (trigEdge && mode[2] && mode[1]) begin
            fastCnt <= modeReg[2] ? 3'(`TCC_FAST_DELAY - 1) : 3'(`TCC_NORMAL_DELAY - 1);
        end else if (fastCnt != 3'h0) begin
            fastCnt <= fastCnt - 3'h1;
        end
    end

    // Output reference
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            outRef       <= 1'b0;
            cmpLessPrev  <= 1'b0;
            wasFrozen    <= 1'b1;
            compareMatch <= 1'b0;
        end else if (!isInput) begin
            cmpLessPrev  <= cmpLess;
            wasFrozen    <= (mode == tcc_pkg::TCC_FROZEN);
            compareMatch <= (counterValue == compareActive);
            case (mode)
                tcc_pkg::TCC_FROZEN:  outRef <= outRef;
                tcc_pkg::TCC_SETHI:   if (counterValue == compareActive) outRef <= 1'b1;
                tcc_pkg::TCC_SETLO:   if (counterValue == compareActive) outRef <= 1'b0;
                tcc_pkg::TCC_TOGGLE:  if (counterValue == compareActive) outRef <= ~outRef;
                tcc_pkg::TCC_FORCELO: outRef <= 1'b0;
                tcc_pkg::TCC_FORCEHI: outRef <= 1'b1;
                tcc_pkg::TCC_PWM1: begin
                    if (modeReg[2] && fastCnt == 3'h1) begin
                        outRef <= 1'b1;
                    end else if (cmpLess != cmpLessPrev || wasFrozen || modeWe) begin
                        outRef <= cmpLess;
                    end
                end
                tcc_pkg::TCC_PWM2: begin
                    if (modeReg[2] && fastCnt == 3'h1) begin
                        outRef <= 1'b0;
                    end else if (cmpLess != cmpLessPrev || wasFrozen || modeWe) begin
                        outRef <= ~cmpLess;
                    end
                end
                default: outRef <= outRef;
            endcase
        end else begin
            compareMatch <= 1'b0;
        end
    end
endmodule

// Behaviour
// - Overcapture flag sets only on capture while event flag set; software writes zero.
// - Lowest bit of overcapture status always reads zero.
// - Break generation clears main output enable, sets break flag, may interrupt, self-clears.
// - Trigger generation sets trigger flag, may interrupt, self-clears.
// - Channel generation on output channel sets its event flag, may interrupt.
// - Channel generation on input captures counter, sets flag, maybe overcapture.
// - Update generation reinitialises counter, clears prescaler, updates preloaded registers.
// - Frozen mode leaves reference unchanged on match.
// - Modes set high or low on match, or force low or high.
// - Toggle mode inverts reference at every match.
// - PWM one active below compare counting up; inactive above compare counting down.
// - PWM two inactive below compare counting up and at or below compare counting down, active otherwise.
// - PWM level changes only on comparison change, leaving frozen, a mode register write or a fast trigger.
// - Reference active high; channel output level follows polarity bit.
// - Without preload compare writes act at once; with preload at update.
// - Fast enable makes trigger edge force compare level in three cycles; without fast enable the edge forces nothing.
// - Selection: output, own pin, neighbouring pin, internal trigger.
// - Selection field writable only while channel enable is zero.
// - Filter field sets sample rate and equal-sample count; zero disables.
// - Capture divider captures every 1, 2, 4 or 8 edges; reset when disabled.
// - Divider ratio change waits for next capture unless enable toggled.
module tcc_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    input  wire logic [15:0] counterValue,
    input  wire logic        countDown,
    input  wire logic        updateIn,
    input  wire logic        trigEdge,
    input  wire logic        trigSource,
    input  wire logic        pin1,
    input  wire logic        pin2,
    output logic             mainOutputEnable,
    output logic             breakIrq,
    output logic             triggerIrq,
    output logic [1:0]       channelIrq,
    output logic             updateRequest,
    output logic [1:0]       channelOutput
);
    logic [7:0]  chMode [2];
    logic [7:0]  chCtrl;
    logic [7:0]  irqEnable;
    logic [7:0]  evStatus;
    logic [7:0]  overStatus;
    logic [7:0]  genPulse;
    logic [15:0] cmpWrite [2];
    logic [1:0]  cmpWe;
    logic [1:0]  modeWe;
    logic [1:0]  capEv;
    logic [1:0]  match;
    logic [1:0]  softEv;
    logic [1:0]  isIn;
    logic [1:0]  outRef;
    logic [1:0]  filt;
    logic [15:0] cmpVal [2];
    logic [15:0] cmpAct [2];
    logic [7:0]  cmpHiLatch [2];
    logic        wrOver;
    logic        wrStatus;

    // Event generation pulse, one cycle, reads as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            genPulse <= `TCC_RST_BYTE;
        end else begin
            genPulse <= (regWrite && regAddr == `TCC_OFF_EVENTGEN) ? regWdata : 8'h00;
        end
    end

    assign softEv   = genPulse[2:1];
    assign wrOver   = regWrite && regAddr == `TCC_OFF_OVERCAPTURE;
    assign wrStatus = regWrite && regAddr == `TCC_OFF_EVSTATUS;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign isIn[i]   = (chMode[i][1:0] != 2'b00);
        assign modeWe[i] = regWrite && regAddr == 8'(`TCC_OFF_CH1MODE + i);
        assign cmpWe[i]  = regWrite && regAddr == 8'(`TCC_OFF_CMP1LO + 2 * i) && !isIn[i];
        assign cmpWrite[i] = {cmpHiLatch[i], regWdata};

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                chMode[i]     <= `TCC_RST_BYTE;
                cmpHiLatch[i] <= `TCC_RST_BYTE;
            end else begin
                if (modeWe[i]) begin
                    chMode[i][7:2] <= regWdata[7:2];
                    if (!chCtrl[4 * i]) begin
                        chMode[i][1:0] <= regWdata[1:0];
                    end
                end
                if (regWrite && regAddr == 8'(`TCC_OFF_CMP1HI + 2 * i)) begin
                    cmpHiLatch[i] <= regWdata;
                end
            end
        end

        tcc_channel u_ch (
            .clk          (clk),
            .sys_rst      (sys_rst),
            .modeReg      (chMode[i]),
            .chEnable     (chCtrl[4 * i]),
            .polarity     (chCtrl[4 * i + 1]),
            .pinOwn       (i == 0 ? pin1 : pin2),
            .pinNeighbour (i == 0 ? pin2 : pin1),
            .trigSource   (trigSource),
            .trigEdge     (trigEdge),
            .countDown    (countDown),
            .counterValue (counterValue),
            .compareWrite (cmpWrite[i]),
            .compareWe    (cmpWe[i]),
            .updateEvent  (updateIn | genPulse[`TCC_BIT_UPDATE]),
            .softEvent    (softEv[i]),
            .modeWe       (modeWe[i]),
            .captureEvent (capEv[i]),
            .compareMatch (match[i]),
            .compareValue (cmpVal[i]),
            .compareActive(cmpAct[i]),
            .outRef       (outRef[i]),
            .filtOut      (filt[i])
        );

        // Event flag and overcapture flag: set wins over clear
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                evStatus[i + 1]   <= 1'b0;
                overStatus[i + 1] <= 1'b0;
            end else begin
                if (capEv[i] || softEv[i] || match[i]) begin
                    evStatus[i + 1] <= 1'b1;
                end else if (wrStatus && !regWdata[i + 1]) begin
                    evStatus[i + 1] <= 1'b0;
                end
                if (isIn[i] && (capEv[i] || softEv[i]) && evStatus[i + 1]) begin
                    overStatus[i + 1] <= 1'b1;
                end else if (wrOver && !regWdata[i + 1]) begin
                    overStatus[i + 1] <= 1'b0;
                end
            end
        end

        // Output from reference and polarity
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                channelOutput[i] <= 1'b0;
                channelIrq[i]    <= 1'b0;
            end else begin
                channelOutput[i] <= chCtrl[4 * i] & mainOutputEnable & (outRef[i] ^ chCtrl[4 * i + 1]);
                channelIrq[i]    <= irqEnable[i + 1] & (capEv[i] | softEv[i] | match[i]);
            end
        end
    end

    assign overStatus[0]   = 1'b0;
    assign overStatus[7:3] = 5'h00;
    assign evStatus[0]     = 1'b0;
    assign evStatus[5:3]   = 3'h0;

    // Break, trigger flags and enables
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evStatus[7]      <= 1'b0;
            evStatus[6]      <= 1'b0;
            mainOutputEnable <= 1'b0;
            breakIrq         <= 1'b0;
            triggerIrq       <= 1'b0;
            updateRequest    <= 1'b0;
            chCtrl           <= `TCC_RST_BYTE;
            irqEnable        <= `TCC_RST_BYTE;
        end else begin
            breakIrq      <= genPulse[`TCC_BIT_BREAK] & irqEnable[7];
            triggerIrq    <= (genPulse[`TCC_BIT_TRIGGER] | trigEdge) & irqEnable[6];
            updateRequest <= genPulse[`TCC_BIT_UPDATE];
            if (genPulse[`TCC_BIT_BREAK]) begin
                evStatus[7] <= 1'b1;
            end else if (wrStatus && !regWdata[7]) begin
                evStatus[7] <= 1'b0;
            end
            if (genPulse[`TCC_BIT_TRIGGER] || trigEdge) begin
                evStatus[6] <= 1'b1;
            end else if (wrStatus && !regWdata[6]) begin
                evStatus[6] <= 1'b0;
            end
            if (genPulse[`TCC_BIT_BREAK]) begin
                mainOutputEnable <= 1'b0;
            end else if (regWrite && regAddr == `TCC_OFF_CHCTRL) begin
                mainOutputEnable <= regWdata[7];
            end
            if (regWrite && regAddr == `TCC_OFF_CHCTRL) begin
                chCtrl <= {1'b0, 1'b0, regWdata[5:4], 2'b00, regWdata[1:0]};
            end
            if (regWrite && regAddr == `TCC_OFF_IRQEN) begin
                irqEnable <= {regWdata[7:6], 3'b000, regWdata[2:1], 1'b0};
            end
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= `TCC_RST_BYTE;
        end else if (regRead) begin
            case (regAddr)
                `TCC_OFF_IRQEN:       regRdata <= irqEnable;
                `TCC_OFF_EVSTATUS:    regRdata <= evStatus;
                `TCC_OFF_OVERCAPTURE: regRdata <= overStatus;
                `TCC_OFF_EVENTGEN:    regRdata <= 8'h00;
                `TCC_OFF_CH1MODE:     regRdata <= chMode[0];
                `TCC_OFF_CH2MODE:     regRdata <= chMode[1];
                `TCC_OFF_CHCTRL:      regRdata <= {mainOutputEnable, chCtrl[6:0]};
                `TCC_OFF_CMP1HI:      regRdata <= cmpVal[0][15:8];
                `TCC_OFF_CMP1LO:      regRdata <= cmpVal[0][7:0];
                `TCC_OFF_CMP2HI:      regRdata <= cmpVal[1][15:8];
                `TCC_OFF_CMP2LO:      regRdata <= cmpVal[1][7:0];
                default:              regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule

`default_nettype wire

//--- bench/tcc_top_asserts.sv
// Checker for the register side of the capture/compare channel.
// Assumes it is bound to tcc_top and sees only its ports.
`include "tcc_cfg.svh"
`default_nettype none

module tcc_top_asserts (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       trigEdge,
    input wire logic       mainOutputEnable,
    input wire logic       breakIrq,
    input wire logic       triggerIrq,
    input wire logic [1:0] channelIrq,
    input wire logic       updateRequest
);
    logic [7:0] irqEn;
    logic       genWr;
    logic       brkWr;
    logic       trgWr;
    logic       chWr;
    logic       updWr;
    logic       rdGen;
    logic       rdOvc;
    assign genWr = regWrite && regAddr == `TCC_OFF_EVENTGEN;
    assign brkWr = genWr && regWdata[7];
    assign trgWr = genWr && regWdata[6];
    assign chWr  = genWr && regWdata[1];
    assign updWr = genWr && regWdata[0];
    assign rdGen = regRead && regAddr == `TCC_OFF_EVENTGEN;
    assign rdOvc = regRead && regAddr == `TCC_OFF_OVERCAPTURE;

    // Shadow of the interrupt enable register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) irqEn <= 8'h00;
        else if (regWrite && regAddr == `TCC_OFF_IRQEN) irqEn <= regWdata;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    brk_moe_a: assert property (brkWr |-> ##[1:3] !mainOutputEnable)
        else $error("break left main output on");
    brk_irq_a: assert property (brkWr && irqEn[7] |-> ##[1:3] breakIrq)
        else $error("break interrupt missing");
    brk_pulse_a: assert property (breakIrq |=> !breakIrq)
        else $error("break interrupt longer than one cycle");
    trg_irq_a: assert property (trgWr && irqEn[6] |-> ##[1:3] triggerIrq)
        else $error("trigger interrupt missing");
    trg_cause_a: assert property (triggerIrq |-> $past(trgWr) || $past(trgWr, 2) || $past(trgWr, 3) || $past(trigEdge, 3)
        || $past(trigEdge) || $past(trigEdge, 2))
        else $error("trigger interrupt without cause");
    ch_irq_a: assert property (chWr && irqEn[1] |-> ##[1:3] channelIrq[0])
        else $error("channel interrupt missing");
    upd_req_a: assert property (updWr |-> ##[1:3] updateRequest)
        else $error("update request missing");
    gen_read_a: assert property ($past(rdGen) |-> regRdata == 8'h00)
        else $error("event generation read not zero");
    ovc_bit_a: assert property ($past(rdOvc) |-> !regRdata[0])
        else $error("overcapture low bit set");

    cover property (brkWr ##2 breakIrq);
    cover property (trgWr ##[1:3] triggerIrq);
    cover property (updateRequest);
endmodule

bind tcc_top tcc_top_asserts chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .trigEdge(trigEdge),
    .mainOutputEnable(mainOutputEnable), .breakIrq(breakIrq), .triggerIrq(triggerIrq),
    .channelIrq(channelIrq), .updateRequest(updateRequest));

`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the capture/compare channel top.
// Assumes tcc_top and its checker are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic        countDown = 1'b0, updateIn = 1'b0, trigEdge = 1'b0, trigSource = 1'b0, pin1 = 1'b0, pin2 = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWdata = 8'h00;
    logic [15:0] counterValue = 16'h0000;
    logic [7:0]  regRdata;
    logic        mainOutputEnable, breakIrq, triggerIrq, updateRequest;
    logic [1:0]  channelIrq, channelOutput;
    int          badCount = 0, testsRun = 0, cycles = 0, brkN = 0, trgN = 0, chN = 0, updN = 0;

    always #20 clk = ~clk;

    tcc_top uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .counterValue(counterValue), .countDown(countDown),
        .updateIn(updateIn), .trigEdge(trigEdge), .trigSource(trigSource), .pin1(pin1), .pin2(pin2),
        .mainOutputEnable(mainOutputEnable), .breakIrq(breakIrq), .triggerIrq(triggerIrq),
        .channelIrq(channelIrq), .updateRequest(updateRequest), .channelOutput(channelOutput));

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        brkN <= brkN + (breakIrq === 1'b1);
        trgN <= trgN + (triggerIrq === 1'b1);
        chN <= chN + (channelIrq[0] === 1'b1);
        updN <= updN + (updateRequest === 1'b1);
        if (cycles == 3000) begin
            badCount++;
            tally_and_finish();
        end
    end

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        check(n, {8'h00, regRdata}, {8'h00, e});
    endtask

    task automatic step(input logic [7:0] m, input logic [15:0] c, input logic e);
        wr(8'h09, m);
        counterValue <= c;
        @(posedge clk);
        counterValue <= c + 16'h0001;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("chOut", {15'h0000, channelOutput[0]}, {15'h0000, e});
    endtask

    task automatic t_reset;
        rd(8'h07, 8'h00, "ovcReset");
        rd(8'h08, 8'h00, "genReset");
        rd(8'h09, 8'h00, "modeReset");
    endtask

    task automatic t_compare;
        wr(8'h05, 8'hc2);
        wr(8'h0b, 8'h81);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h10);
        step(8'h50, 16'h0005, 1'b1);
        step(8'h40, 16'h0005, 1'b0);
        step(8'h10, 16'h0010, 1'b1);
        step(8'h00, 16'h0010, 1'b1);
        step(8'h20, 16'h0010, 1'b0);
        step(8'h30, 16'h0005, 1'b0);
        step(8'h30, 16'h0010, 1'b1);
        step(8'h30, 16'h0010, 1'b0);
        wr(8'h09, 8'h08);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h20);
        step(8'h68, 16'h0018, 1'b0);
        @(posedge clk) updateIn <= 1'b1;
        @(posedge clk) updateIn <= 1'b0;
        repeat (6) @(posedge clk);
        check("preload", {15'h0000, channelOutput[0]}, 16'h0001);
        wr(8'h0b, 8'h83);
        repeat (6) @(posedge clk);
        check("polarity", {15'h0000, channelOutput[0]}, 16'h0000);
        wr(8'h0b, 8'h81);
        step(8'h08, 16'h0018, 1'b1);
        step(8'h78, 16'h0018, 1'b0);
        @(posedge clk) countDown <= 1'b1;
        step(8'h08, 16'h0028, 1'b0);
        step(8'h68, 16'h0028, 1'b0);
        step(8'h68, 16'h0018, 1'b1);
        @(posedge clk) countDown <= 1'b0;
        step(8'h6c, 16'h0028, 1'b0);
        @(posedge clk) trigEdge <= 1'b1;
        @(posedge clk) trigEdge <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("fast", {15'h0000, channelOutput[0]}, 16'h0001);
    endtask

    task automatic t_capture;
        int c0;
        wr(8'h0b, 8'h80);
        wr(8'h09, 8'h01);
        wr(8'h0b, 8'h81);
        wr(8'h06, 8'h00);
        c0 = chN;
        counterValue <= 16'h1234;
        wr(8'h08, 8'h02);
        repeat (3) @(posedge clk);
        wr(8'h08, 8'h02);
        repeat (3) @(posedge clk);
        check("capIrq", 16'(chN - c0), 16'h0002);
        rd(8'h07, 8'h02, "ovcSet");
        rd(8'h11, 8'h12, "capHi");
        rd(8'h12, 8'h34, "capLo");
        wr(8'h07, 8'h00);
        rd(8'h07, 8'h00, "ovcClear");
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00, "ovcOnes");
        wr(8'h09, 8'h00);
        rd(8'h09, 8'h01, "selLocked");
        @(posedge clk) counterValue <= 16'h0077;
        pin1 <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h12, 8'h77, "pinCap");
    endtask

    task automatic t_events;
        int t0;
        int u0;
        int b0;
        t0 = trgN;
        u0 = updN;
        b0 = brkN;
        wr(8'h06, 8'h00);
        wr(8'h08, 8'h40);
        repeat (3) @(posedge clk);
        rd(8'h06, 8'h40, "trgFlag");
        rd(8'h08, 8'h00, "genRead");
        check("trgIrq", 16'(trgN - t0), 16'h0001);
        wr(8'h08, 8'h01);
        repeat (3) @(posedge clk);
        check("updReq", 16'(updN - u0), 16'h0001);
        wr(8'h08, 8'h80);
        repeat (3) @(posedge clk);
        check("moe", {15'h0000, mainOutputEnable}, 16'h0000);
        rd(8'h06, 8'hc0, "brkFlag");
        check("brkIrq", 16'(brkN - b0), 16'h0001);
    endtask

    task automatic tally_and_finish;
        if (badCount == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_compare();
        t_capture();
        t_events();
        tally_and_finish();
    end
endmodule

`default_nettype wire
